/* logic/srocp_params.svh */
// Register offsets, field positions, reset values and codes of the ratio/output control port
`ifndef SROCP_PARAMS_SVH
`define SROCP_PARAMS_SVH
`define SROCP_OFS_ID 7'h01
`define SROCP_OFS_CTRL 7'h02
`define SROCP_OFS_CFG1 7'h03
`define SROCP_OFS_GLOB 7'h05
`define SROCP_OFS_RATIO0 7'h06
`define SROCP_OFS_RATIO1 7'h07
`define SROCP_OFS_RATIO2 7'h08
`define SROCP_OFS_RATIO3 7'h09
`define SROCP_OFS_FUNC1 7'h16
`define SROCP_OFS_FUNC2 7'h17
`define SROCP_CTRL_UNLOCK 7
`define SROCP_CTRL_AUXDIS 1
`define SROCP_CTRL_MAINDIS 0
`define SROCP_CFG1_MOD_LSB 5
`define SROCP_CFG1_SRC_LSB 1
`define SROCP_CFG1_EN1 0
`define SROCP_GLOB_FREEZE 3
`define SROCP_GLOB_EN2 0
`define SROCP_FUNC1_LOCKCFG 6
`define SROCP_FUNC1_DIV_LSB 3
`define SROCP_FUNC2_UNL 4
`define SROCP_RST_BYTE 8'h00
`define SROCP_RST_RATIO 32'h0000_0000
`define SROCP_SPI_CHIP_ADDR 8'h9e
`define SROCP_I2C_ADDR_HI 6'h27
`define SROCP_AUX_REF 2'h0
`define SROCP_AUX_PLL 2'h2
`define SROCP_AUX_LOCK 2'h3
// Identity values are arbitrary
`define SROCP_DEV_CODE 5'h15
`define SROCP_REV_CODE 3'h1
`endif

/* logic/srocp_pkg.sv */
// Types shared by the ratio/output control port
package srocp_pkg;
  // Clock-domain I2C engine states
  typedef enum logic [2:0] {I2C_IDLE, I2C_RX, I2C_RX_ACK, I2C_TX, I2C_TX_ACK} srocp_i2c_state_t;
  // One register write request
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } srocp_wr_t;
  // Controls for the output driver / gating cells
  typedef struct packed {
    logic main_oe_n;
    logic main_force_low;
    logic aux_oe_n;
    logic aux_force_low;
    logic [1:0] aux_sel;
    logic lock_level;
    logic lock_open_drain;
  } srocp_pin_ctl_t;
endpackage : srocp_pkg

/* logic/srocp_top.sv */
// Control port, register bank, ratio and output control of the clock synthesizer
`timescale 1ns/1ps
`include "srocp_params.svh"
module srocp_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ctl_clk,
  input wire logic ctl_data_in,
  output logic ctl_data_out,
  output logic ctl_data_oe_n,
  input wire logic ad_cs_pin,
  input wire logic pll_locked,
  input wire logic ref_present,
  input wire logic ref_discontinuity,
  output srocp_pkg::srocp_pin_ctl_t pin_ctl,
  output logic [31:0] effective_ratio,
  output logic [34:0] fractional_n_value,
  output logic relock_request,
  output logic spi_mode
);
  import srocp_pkg::*;

  // Synchroniser bit positions
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_CS = 2;
  localparam int SY_LOCK = 3;
  localparam int SY_REF = 4;
  localparam int SY_DISC = 5;
  localparam int SY_TGL = 6;

  // Link domain: shift count, shifter, finished byte and its toggle
  logic [2:0] lk_cnt;
  logic [6:0] lk_sh;
  logic [7:0] lk_byte;
  logic lk_tgl;

  // SPI shifter; chip select high ends the frame without needing a link edge
  // rising-edge capture
  always_ff @(posedge ctl_clk or posedge ad_cs_pin)
  begin
    if (ad_cs_pin)
    begin
      lk_cnt <= 3'h0;
      lk_sh <= 7'h00;
    end
    else
    begin
      lk_cnt <= lk_cnt + 3'h1;
      lk_sh <= {lk_sh[5:0], ctl_data_in};
    end
  end

  // Byte hand-off; the toggle survives chip select so no byte is lost at frame end
  always_ff @(posedge ctl_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lk_byte <= 8'h00;
      lk_tgl <= 1'b0;
    end
    else if (!ad_cs_pin && lk_cnt == 3'h7)
    begin
      lk_byte <= {lk_sh, ctl_data_in};
      lk_tgl <= ~lk_tgl;
    end
  end

  // Two-stage synchronisers and the previous value for edge detection
  logic [6:0] sy1;
  logic [6:0] sy;
  logic [6:0] sy_prev;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      // Clock, data and chip select idle high, so no false edge follows reset
      sy1 <= 7'h07;
      sy <= 7'h07;
      sy_prev <= 7'h07;
    end
    else
    begin
      sy1 <= {lk_tgl, ref_discontinuity, ref_present, pll_locked, ad_cs_pin, ctl_data_in, ctl_clk};
      sy <= sy1;
      sy_prev <= sy;
    end
  end

  // Edge and condition decode on synchronised pins
  logic scl_rise, scl_fall, i2c_start, i2c_stop, spi_evt;
  assign scl_rise = sy[SY_SCL] && !sy_prev[SY_SCL];
  assign scl_fall = !sy[SY_SCL] && sy_prev[SY_SCL];
  assign i2c_start = sy[SY_SCL] && sy_prev[SY_SCL] && sy_prev[SY_SDA] && !sy[SY_SDA];
  assign i2c_stop = sy[SY_SCL] && sy_prev[SY_SCL] && !sy_prev[SY_SDA] && sy[SY_SDA];
  assign spi_evt = sy[SY_TGL] ^ sy_prev[SY_TGL];

  // Interface mode latch; once SPI is seen it stays until reset
  // falling chip-select picks SPI
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      spi_mode <= 1'b0;
    else if (sy_prev[SY_CS] && !sy[SY_CS])
      spi_mode <= 1'b1;
  end

  // SPI framing: byte index and chip-address match
  logic [1:0] spi_idx;
  logic spi_sel;
  always_ff @(posedge clk)
  begin
    if (sys_rst || sy[SY_CS])
    begin
      spi_idx <= 2'h0;
      spi_sel <= 1'b0;
    end
    else if (spi_evt && spi_mode)
    begin
      // first byte must be the chip address
      if (spi_idx == 2'h0)
        spi_sel <= (lk_byte == `SROCP_SPI_CHIP_ADDR);
      if (spi_idx != 2'h2)
        spi_idx <= spi_idx + 2'h1;
    end
  end

  // I2C engine state
  srocp_i2c_state_t i2c_state;
  logic [3:0] i2c_cnt;
  logic [7:0] i2c_sh;
  logic [1:0] i2c_idx;
  logic i2c_read;
  logic i2c_ack_ok;
  logic [7:0] ptr;
  logic [7:0] rd_byte;
  logic addr_hit;
  logic rx_done;
  // six fixed bits, then the strap level
  assign addr_hit = (i2c_sh[7:1] == {`SROCP_I2C_ADDR_HI, sy[SY_CS]});
  assign rx_done = scl_fall && i2c_state == I2C_RX && i2c_cnt == 4'h8;

  // I2C byte engine, sampled on the system clock
  always_ff @(posedge clk)
  begin
    if (sys_rst || spi_mode || i2c_stop)
    begin
      i2c_state <= I2C_IDLE;
      i2c_cnt <= 4'h0;
      i2c_idx <= 2'h0;
      i2c_read <= 1'b0;
      ctl_data_oe_n <= 1'b1;
    end
    else if (i2c_start)
    begin
      // Repeated start restarts the address phase
      i2c_state <= I2C_RX;
      i2c_cnt <= 4'h0;
      i2c_idx <= 2'h0;
      ctl_data_oe_n <= 1'b1;
    end
    else if (scl_rise)
    begin
      if (i2c_state == I2C_RX)
      begin
        i2c_sh <= {i2c_sh[6:0], sy[SY_SDA]};
        i2c_cnt <= i2c_cnt + 4'h1;
      end
      if (i2c_state == I2C_TX_ACK)
        i2c_ack_ok <= !sy[SY_SDA];
    end
    else if (scl_fall)
    begin
      unique case (i2c_state)
        I2C_IDLE:
          ctl_data_oe_n <= 1'b1;
        I2C_RX:
          if (i2c_cnt == 4'h8)
          begin
            i2c_cnt <= 4'h0;
            if (i2c_idx != 2'h2)
              i2c_idx <= i2c_idx + 2'h1;
            // foreign address: go quiet until the next start
            if (i2c_idx == 2'h0 && !addr_hit)
              i2c_state <= I2C_IDLE;
            else
            begin
              // pull data low for the acknowledge bit
              ctl_data_oe_n <= 1'b0;
              i2c_state <= I2C_RX_ACK;
              if (i2c_idx == 2'h0)
                i2c_read <= i2c_sh[0];
            end
          end
        I2C_RX_ACK:
          if (i2c_read)
          begin
            // read returns the pointed register, msb first
            i2c_state <= I2C_TX;
            i2c_sh <= rd_byte;
            ctl_data_oe_n <= rd_byte[7];
            i2c_cnt <= 4'h1;
          end
          else
          begin
            ctl_data_oe_n <= 1'b1;
            i2c_state <= I2C_RX;
          end
        I2C_TX:
          if (i2c_cnt == 4'h8)
          begin
            // Release the line so the host can acknowledge
            ctl_data_oe_n <= 1'b1;
            i2c_state <= I2C_TX_ACK;
          end
          else
          begin
            ctl_data_oe_n <= i2c_sh[3'h7 - i2c_cnt[2:0]];
            i2c_cnt <= i2c_cnt + 4'h1;
          end
        I2C_TX_ACK:
          if (i2c_ack_ok)
          begin
            // host ack asks for the next byte
            i2c_state <= I2C_TX;
            i2c_sh <= rd_byte;
            ctl_data_oe_n <= rd_byte[7];
            i2c_cnt <= 4'h1;
          end
          else
            i2c_state <= I2C_IDLE;
      endcase
    end
  end

  // The data pin is only ever pulled low; release means high impedance
  always_ff @(posedge clk)
  begin
    ctl_data_out <= 1'b0;
  end

  // Pointer load and write strobes from both engines; read-step strobe from the I2C engine only
  logic map_ld, wr_any, rd_step;
  logic [7:0] wr_data;
  logic [7:0] map_data;
  assign map_ld = (rx_done && i2c_idx == 2'h1) || (spi_evt && spi_sel && spi_idx == 2'h1);
  assign wr_any = (rx_done && i2c_idx == 2'h2) || (spi_evt && spi_sel && spi_idx == 2'h2);
  assign rd_step = scl_fall && i2c_state == I2C_TX && i2c_cnt == 4'h8;
  assign wr_data = spi_mode ? lk_byte : i2c_sh;
  assign map_data = wr_data;

  // Register pointer
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ptr <= `SROCP_RST_BYTE;
    // top bit is the auto-step flag
    else if (map_ld)
      ptr <= map_data;
    // step after each byte only when enabled
    else if ((wr_any || rd_step) && ptr[7])
      ptr[6:0] <= ptr[6:0] + 7'h1;
  end

  // Buffered (software-visible) register copies
  logic sh_maindis, sh_auxdis, sh_en1, sh_en2, sh_freeze, sh_lockcfg, sh_unl;
  logic [2:0] sh_mod;
  logic [1:0] sh_src, sh_div;
  logic [31:0] sh_ratio;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      {sh_maindis, sh_auxdis, sh_en1, sh_en2, sh_freeze, sh_lockcfg, sh_unl} <= 7'h00;
      {sh_mod, sh_src, sh_div} <= 7'h00;
      sh_ratio <= `SROCP_RST_RATIO;
    end
    else if (wr_any)
    begin
      unique case (ptr[6:0])
        `SROCP_OFS_CTRL:
        begin
          sh_auxdis <= wr_data[`SROCP_CTRL_AUXDIS];
          sh_maindis <= wr_data[`SROCP_CTRL_MAINDIS];
        end
        `SROCP_OFS_CFG1:
        begin
          sh_mod <= wr_data[`SROCP_CFG1_MOD_LSB +: 3];
          sh_src <= wr_data[`SROCP_CFG1_SRC_LSB +: 2];
          sh_en1 <= wr_data[`SROCP_CFG1_EN1];
        end
        `SROCP_OFS_GLOB:
        begin
          sh_freeze <= wr_data[`SROCP_GLOB_FREEZE];
          sh_en2 <= wr_data[`SROCP_GLOB_EN2];
        end
        `SROCP_OFS_RATIO0: sh_ratio[31:24] <= wr_data;
        `SROCP_OFS_RATIO1: sh_ratio[23:16] <= wr_data;
        `SROCP_OFS_RATIO2: sh_ratio[15:8] <= wr_data;
        `SROCP_OFS_RATIO3: sh_ratio[7:0] <= wr_data;
        `SROCP_OFS_FUNC1:
        begin
          sh_lockcfg <= wr_data[`SROCP_FUNC1_LOCKCFG];
          sh_div <= wr_data[`SROCP_FUNC1_DIV_LSB +: 2];
        end
        `SROCP_OFS_FUNC2: sh_unl <= wr_data[`SROCP_FUNC2_UNL];
        default: ;
      endcase
    end
  end

  // Applied settings follow the buffer while freeze is clear
  logic ap_maindis, ap_auxdis, ap_en1, ap_en2, ap_lockcfg, ap_unl;
  logic [2:0] ap_mod;
  logic [1:0] ap_src, ap_div;
  logic [31:0] ap_ratio;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      {ap_maindis, ap_auxdis, ap_en1, ap_en2, ap_lockcfg, ap_unl} <= 6'h00;
      {ap_mod, ap_src, ap_div} <= 7'h00;
      ap_ratio <= `SROCP_RST_RATIO;
    end
    // one copy step releases every held setting together
    else if (!sh_freeze)
    begin
      {ap_maindis, ap_auxdis, ap_en1, ap_en2} <= {sh_maindis, sh_auxdis, sh_en1, sh_en2};
      {ap_lockcfg, ap_unl, ap_mod, ap_src, ap_div} <= {sh_lockcfg, sh_unl, sh_mod, sh_src, sh_div};
      ap_ratio <= sh_ratio;
    end
  end

  // Sticky unlock flag; a new unlock wins over the read that clears it
  logic unlock_sticky;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      unlock_sticky <= 1'b0;
    else if (!sy[SY_LOCK])
      unlock_sticky <= 1'b1;
    else if (rd_step && ptr[6:0] == `SROCP_OFS_CTRL)
      unlock_sticky <= 1'b0;
  end

  // Read data for the I2C engine; reserved bits read zero
  always_comb
  begin
    rd_byte = `SROCP_RST_BYTE;
    unique case (ptr[6:0])
      // Identity value is arbitrary
      `SROCP_OFS_ID: rd_byte = {`SROCP_DEV_CODE, `SROCP_REV_CODE};
      `SROCP_OFS_CTRL: rd_byte = {unlock_sticky, 5'h00, sh_auxdis, sh_maindis};
      `SROCP_OFS_CFG1: rd_byte = {sh_mod, 2'h0, sh_src, sh_en1};
      `SROCP_OFS_GLOB: rd_byte = {4'h0, sh_freeze, 2'h0, sh_en2};
      `SROCP_OFS_RATIO0: rd_byte = sh_ratio[31:24];
      `SROCP_OFS_RATIO1: rd_byte = sh_ratio[23:16];
      `SROCP_OFS_RATIO2: rd_byte = sh_ratio[15:8];
      `SROCP_OFS_RATIO3: rd_byte = sh_ratio[7:0];
      `SROCP_OFS_FUNC1: rd_byte = {1'b0, sh_lockcfg, 1'b0, sh_div, 3'h0};
      `SROCP_OFS_FUNC2: rd_byte = {3'h0, sh_unl, 4'h0};
      default: rd_byte = `SROCP_RST_BYTE;
    endcase
  end

  // Ratio arithmetic; overflow is the host's to avoid, bits shifted out are lost
  logic [31:0] next_eff;
  logic [34:0] next_fn;
  always_comb
  begin
    // low codes shift left, high codes shift right one further
    if (ap_mod[2])
      next_eff = ap_ratio >> ({1'b0, ap_mod[1:0]} + 3'h1);
    else
      next_eff = ap_ratio << ap_mod[1:0];
    // reference divider folded in so the host never corrects for it
    next_fn = {3'h0, next_eff} << ap_div;
  end

  // Ratio outputs and relock request
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      effective_ratio <= `SROCP_RST_RATIO;
      fractional_n_value <= 35'h0;
      relock_request <= 1'b0;
    end
    else
    begin
      effective_ratio <= next_eff;
      fractional_n_value <= next_fn;
      // new fractional value or reference break forces relock
      relock_request <= (next_fn != fractional_n_value)
        || (sy[SY_DISC] && !sy_prev[SY_DISC]);
    end
  end

  // Device may run once both enables are applied and the effective (shifted) ratio is nonzero
  logic cfg_ok, unlock_shown;
  assign cfg_ok = ap_en1 && ap_en2 && (next_eff != 32'h0);
  // without a reference the indicator cannot report unlock
  assign unlock_shown = sy[SY_REF] && !sy[SY_LOCK];

  // Output-stage controls; each field changes once per clock, and the gating
  // cells downstream only act on a clock-low phase, so no runt period appears
  // single registered update per change
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_ctl <= '{main_oe_n: 1'b0, main_force_low: 1'b1, aux_oe_n: 1'b0,
        aux_force_low: 1'b1, aux_sel: `SROCP_AUX_REF, lock_level: 1'b0, lock_open_drain: 1'b0};
    end
    else
    begin
      pin_ctl.main_oe_n <= cfg_ok && ap_maindis;
      // hold low while unlocked unless bypass bit set
      pin_ctl.main_force_low <= !cfg_ok || (!sy[SY_LOCK] && !ap_unl);
      pin_ctl.aux_oe_n <= cfg_ok && ap_auxdis;
      // reserved code 01 keeps the pin low
      pin_ctl.aux_force_low <= !cfg_ok || (ap_src == 2'h1);
      pin_ctl.aux_sel <= ap_src;
      // open-drain active-low when set, push-pull active-high otherwise
      // the lock level is registered once per clock like the other output-stage fields
      pin_ctl.lock_level <= ap_lockcfg ? !unlock_shown : unlock_shown;
      pin_ctl.lock_open_drain <= ap_lockcfg;
    end
  end

  // Checks on the clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_not_ready;
    !cfg_ok;
  endsequence
  sequence s_frozen_two;
    sh_freeze ##1 sh_freeze;
  endsequence

  chk_main_hiz: assert property (cfg_ok && ap_maindis |=> pin_ctl.main_oe_n)
    else $error("main output not high impedance");
  chk_unlock_low: assert property (!sy[SY_LOCK] && !ap_unl |=> pin_ctl.main_force_low)
    else $error("main output not forced low on unlock");
  chk_not_ready: assert property (s_not_ready |=> pin_ctl.main_force_low && pin_ctl.aux_force_low
    && !pin_ctl.main_oe_n)
    else $error("outputs not low before configuration");
  chk_enable_pair: assert property (!ap_en1 || !ap_en2 |=> pin_ctl.main_force_low)
    else $error("output released without both enables");
  chk_freeze_hold: assert property (s_frozen_two |-> $stable(ap_ratio))
    else $error("applied ratio moved while frozen");
  chk_ptr_step: assert property ((wr_any || rd_step) && !map_ld && ptr[7]
    |=> ptr[6:0] == $past(ptr[6:0]) + 7'h1)
    else $error("pointer did not step");
  chk_ptr_hold: assert property ((wr_any || rd_step) && !map_ld && !ptr[7] |=> $stable(ptr))
    else $error("pointer moved without auto-step");
  chk_addr_miss: assert property (rx_done && i2c_idx == 2'h0 && !addr_hit
    |=> i2c_state == I2C_IDLE && ctl_data_oe_n ##1 !wr_any)
    else $error("foreign address not ignored");
  chk_ack_drive: assert property (rx_done && (i2c_idx != 2'h0 || addr_hit)
    |=> !ctl_data_oe_n && i2c_state == I2C_RX_ACK)
    else $error("no acknowledge driven");
  chk_relock: assert property (next_fn != fractional_n_value |=> relock_request)
    else $error("ratio change without relock request");
  chk_spi_pick: assert property (sy_prev[SY_CS] && !sy[SY_CS] |=> spi_mode [*3])
    else $error("spi mode not latched");
  chk_aux_hiz: assert property (cfg_ok && ap_auxdis |=> pin_ctl.aux_oe_n)
    else $error("aux output not high impedance");
endmodule : srocp_top

/* tb/srocp_host.sv */
// Host model that masters the serial control port
`timescale 1ns/1ps
module srocp_host (
  output logic scl,
  output logic sda,
  output logic cs,
  input wire logic sda_wire
);
  // Two-wire phase; stays well above the 40 ns minimum
  localparam int T = 100;
  // Lines idle high, as the pull-ups leave them
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
    cs = 1'b1;
  end
  // Start condition: data falls while clock is high
  task automatic start();
    sda = 1'b1;
    #T scl = 1'b1;
    #T sda = 1'b0;
    #T scl = 1'b0;
  endtask : start
  // Stop condition: data rises while clock is high
  task automatic stop();
    sda = 1'b0;
    #T scl = 1'b1;
    #T sda = 1'b1;
    #T;
  endtask : stop
  // Eight bits and the acknowledge slot; data changes only while clock is low
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack);
    logic [8:0] v;
    logic [8:0] r;
    v = {tx, ack_in};
    for (int i = 8; i >= 0; i--)
    begin
      sda = v[i];
      #T scl = 1'b1;
      #T r[i] = sda_wire;
      scl = 1'b0;
    end
    rx = r[8:1];
    ack = r[0];
  endtask : xfer
  // Write frame: address, pointer, n data bytes msb first
  task automatic wr(input logic [7:0] adr, input logic [7:0] ptr, input logic [31:0] d,
                    input int n, output logic ok);
    logic [7:0] r;
    logic a;
    start();
    xfer(adr, 1'b1, r, a);
    ok = (a === 1'b0);
    if (ok)
    begin
      xfer(ptr, 1'b1, r, a);
      ok = ok && (a === 1'b0);
      for (int k = n - 1; k >= 0; k--)
      begin
        xfer(d[8*k+:8], 1'b1, r, a);
        ok = ok && (a === 1'b0);
      end
    end
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] adr, input logic [7:0] ptr, input int n,
                    output logic [31:0] d);
    logic [7:0] r;
    logic a;
    logic ok;
    wr(adr, ptr, 32'h0000_0000, 0, ok);
    start();
    xfer(adr | 8'h01, 1'b1, r, a);
    d = 32'h0000_0000;
    for (int k = n - 1; k >= 0; k--)
    begin
      xfer(8'hff, k == 0, r, a);
      d[8*k+:8] = r;
    end
    stop();
  endtask : rd
  // chip, pointer, data order
  // Link clock at 12 ns runs only inside the frame
  task automatic spi(input logic [7:0] chip, input logic [7:0] ptr, input logic [31:0] d,
                     input int n);
    logic [47:0] s;
    s = {chip, ptr, d << (8 * (4 - n))};
    cs = 1'b0;
    #20;
    for (int i = 47; i >= 32 - 8 * n; i--)
    begin
      scl = 1'b0;
      sda = s[i];
      #6 scl = 1'b1;
      #6;
    end
    // Chip select held past the last rising edge
    #70 cs = 1'b1;
    sda = 1'b1;
  endtask : spi
endmodule : srocp_host

/* tb/srocp_top_bench.sv */
// Self-checking bench of the ratio and output control port
`timescale 1ns/1ps
module srocp_top_bench;
  import srocp_pkg::*;
  logic clk;
  logic sys_rst;
  logic scl;
  logic host_sda;
  logic cs;
  logic sda_wire;
  logic pll_locked;
  logic ref_present;
  logic ref_disc;
  logic data_out;
  logic data_oe_n;
  srocp_pin_ctl_t pin_ctl;
  logic [31:0] eff;
  logic [34:0] fnv;
  logic relock;
  logic spi_mode;
  logic ok;
  logic [31:0] rdat;
  int num_errors = 0;
  int num_checks = 0;
  int relock_cnt = 0;
  // Open-drain data wire: device can only pull low
  assign sda_wire = data_oe_n ? host_sda : data_out;
  srocp_top i_dut (.clk(clk), .sys_rst(sys_rst), .ctl_clk(scl), .ctl_data_in(sda_wire),
    .ctl_data_out(data_out), .ctl_data_oe_n(data_oe_n), .ad_cs_pin(cs),
    .pll_locked(pll_locked), .ref_present(ref_present), .ref_discontinuity(ref_disc),
    .pin_ctl(pin_ctl), .effective_ratio(eff), .fractional_n_value(fnv),
    .relock_request(relock), .spi_mode(spi_mode));
  srocp_host i_host (.scl(scl), .sda(host_sda), .cs(cs), .sda_wire(sda_wire));
  // System clock, 100 MHz
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Counts relock pulses so tests can compare before and after
  always @(posedge clk)
    if (relock === 1'b1)
      relock_cnt <= relock_cnt + 1;
  task automatic check(input string nm, input logic [34:0] seen, input logic [34:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Lets the sync chain and register update land
  task automatic settle();
    repeat (10) @(posedge clk);
    #1;
  endtask : settle
  task automatic wr1(input logic [7:0] p, input logic [7:0] d);
    i_host.wr(8'h9e, p, {24'h0, d}, 1, ok);
    settle();
  endtask : wr1
  task automatic t_i2c();
    int c0;
    c0 = relock_cnt;
    // ratio kept far below the integer limit
    i_host.wr(8'h9e, 8'h86, 32'h0012_3456, 4, ok);
    settle();
    check("ack", ok, 1'b1);
    check("eff", eff, 35'h0012_3456);
    check("relock", relock_cnt > c0, 1'b1);
    i_host.rd(8'h9e, 8'h86, 4, rdat);
    check("read", rdat, 35'h0012_3456);
    i_host.wr(8'h9c, 8'h86, 32'h0000_0001, 4, ok);
    settle();
    check("nack", ok, 1'b0);
    check("eff kept", eff, 35'h0012_3456);
  endtask : t_i2c
  task automatic t_modifier();
    logic [31:0] r;
    r = 32'h0010_0000;
    i_host.wr(8'h9e, 8'h86, r, 4, ok);
    // Two bytes to a fixed pointer: the second overwrites the first
    i_host.wr(8'h9e, 8'h03, 32'h0000_2040, 2, ok);
    settle();
    check("fixed ptr", eff, r << 2);
    for (int c = 0; c < 8; c++)
    begin
      wr1(8'h03, {c[2:0], 5'h00});
      check("modifier", eff, (c < 4) ? (r << c) : (r >> (c - 3)));
    end
  endtask : t_modifier
  task automatic t_outputs();
    logic [1:0] srcs [3] = '{2'h0, 2'h2, 2'h3};
    wr1(8'h03, 8'h01);
    check("one enable", pin_ctl.main_force_low, 1'b1);
    wr1(8'h05, 8'h01);
    check("both enables", pin_ctl.main_force_low, 1'b0);
    @(posedge clk);
    #1 pll_locked = 1'b0;
    settle();
    check("unlock low", pin_ctl.main_force_low, 1'b1);
    wr1(8'h17, 8'h10);
    check("unlock bypass", pin_ctl.main_force_low, 1'b0);
    wr1(8'h17, 8'h00);
    wr1(8'h02, 8'h01);
    check("main hiz", {pin_ctl.main_oe_n, pin_ctl.aux_oe_n}, 2'b10);
    wr1(8'h02, 8'h02);
    check("aux hiz", {pin_ctl.main_oe_n, pin_ctl.aux_oe_n}, 2'b01);
    wr1(8'h02, 8'h00);
    foreach (srcs[i])
    begin
      wr1(8'h03, {5'h00, srcs[i], 1'b1});
      check("aux source", pin_ctl.aux_sel, srcs[i]);
    end
    // Reserved source code keeps the auxiliary pin low
    wr1(8'h03, 8'h03);
    check("aux reserved", pin_ctl.aux_force_low, 1'b1);
    wr1(8'h16, 8'h10);
    check("lock push", {pin_ctl.lock_level, pin_ctl.lock_open_drain}, 2'b10);
    check("divider", fnv, 35'h0010_0000 << 2);
    wr1(8'h16, 8'h50);
    check("lock drain", {pin_ctl.lock_level, pin_ctl.lock_open_drain}, 2'b01);
    @(posedge clk);
    #1 ref_present = 1'b0;
    settle();
    check("no ref", pin_ctl.lock_level, 1'b1);
    @(posedge clk);
    #1 ref_present = 1'b1;
    pll_locked = 1'b1;
    wr1(8'h16, 8'h00);
    // Unlock flag sticks after relock and clears once it has been read
    i_host.rd(8'h9e, 8'h02, 1, rdat);
    check("unlock sticky", rdat, 35'h80);
    i_host.rd(8'h9e, 8'h02, 1, rdat);
    check("unlock cleared", rdat, 35'h00);
  endtask : t_outputs
  task automatic t_freeze();
    int c0;
    wr1(8'h05, 8'h09);
    i_host.wr(8'h9e, 8'h86, 32'h0020_0000, 4, ok);
    settle();
    check("frozen", eff, 35'h0010_0000);
    wr1(8'h05, 8'h01);
    check("thawed", eff, 35'h0020_0000);
    c0 = relock_cnt;
    @(posedge clk);
    #1 ref_disc = 1'b1;
    settle();
    ref_disc = 1'b0;
    check("ref fault", relock_cnt > c0, 1'b1);
  endtask : t_freeze
  task automatic t_spi();
    i_host.spi(8'h9c, 8'h86, 32'h0040_0000, 4);
    settle();
    check("spi mode", spi_mode, 1'b1);
    check("spi wrong chip", eff, 35'h0020_0000);
    i_host.spi(8'h9e, 8'h86, 32'h0030_0000, 4);
    settle();
    check("spi write", eff, 35'h0030_0000);
    i_host.spi(8'h9e, 8'h06, 32'h0000_0201, 2);
    settle();
    check("spi fixed ptr", eff, 35'h0130_0000);
  endtask : t_spi
  task automatic results();
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  // Watchdog well beyond the expected run length
  initial
  begin
    #800000;
    num_errors++;
    results();
  end
  initial
  begin
    sys_rst = 1'b1;
    pll_locked = 1'b1;
    ref_present = 1'b1;
    ref_disc = 1'b0;
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("reset low", {pin_ctl.main_force_low, pin_ctl.aux_force_low}, 2'b11);
    check("reset mode", spi_mode, 1'b0);
    // Two-wire traffic must come first: a chip-select fall is sticky
    t_i2c();
    t_modifier();
    t_outputs();
    t_freeze();
    t_spi();
    results();
  end
endmodule : srocp_top_bench
